// file: core/line_io_pkg.sv
// Shared constants, register map and line kinds of the line I/O control block.
package line_io_pkg;

    // Line population: physical connector lines first, then virtual trigger lines.
    localparam int NUM_PHYS  = 4;
    localparam int NUM_VIRT  = 2;
    localparam int NUM_LINES = NUM_PHYS + NUM_VIRT;
    localparam int USER_BITS = 8;
    localparam int INT_SRCS  = 8;
    localparam int IDX_W     = 3;
    localparam int SRC_W     = 5;
    localparam int ADDR_W    = 8;
    localparam int DATA_W    = 32;
    localparam int SRC_VEC_W = 32;

    // Output source codes: off, then user bits, then internal sources.
    localparam logic [SRC_W-1:0] SRC_OFF       = 5'h00;
    localparam logic [SRC_W-1:0] SRC_USER_BASE = 5'h01;
    localparam logic [SRC_W-1:0] SRC_INT_BASE  = 5'h09;
    localparam logic [SRC_W-1:0] SRC_COUNT     = 5'h11;

    // Register byte offsets.
    localparam logic [ADDR_W-1:0] OFS_LINE_SEL   = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_LINE_DIR   = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_LINE_INV   = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_LINE_SRC   = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_LINE_LEVEL = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_ALL_LEVEL  = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_USER_SEL   = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_USER_VAL   = 8'h1C;
    localparam logic [ADDR_W-1:0] OFS_USER_WORD  = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_USER_MASK  = 8'h24;
    localparam logic [ADDR_W-1:0] OFS_LINE_KIND  = 8'h28;

    // Reset values.
    localparam logic [IDX_W-1:0]     RST_LINE_SEL = 3'h0;
    localparam logic [IDX_W-1:0]     RST_USER_SEL = 3'h0;
    localparam logic [USER_BITS-1:0] RST_USER     = 8'h00;
    localparam logic [USER_BITS-1:0] RST_MASK     = 8'hFF;
    localparam logic                 RST_DIR      = 1'b0;
    localparam logic                 RST_INV      = 1'b0;

    // Kinds of line control block.
    typedef enum logic [1:0] {
        KIND_BIDIR,
        KIND_IN_ONLY,
        KIND_OUT_ONLY,
        KIND_FIXED
    } line_kind_t;

    localparam line_kind_t LINE_KIND [NUM_LINES] = '{
        KIND_BIDIR, KIND_BIDIR, KIND_IN_ONLY, KIND_FIXED, KIND_OUT_ONLY, KIND_IN_ONLY
    };

    // Settings of a hard-wired line.
    localparam logic             FIXED_DIR = 1'b1;
    localparam logic             FIXED_INV = 1'b0;
    localparam logic [SRC_W-1:0] FIXED_SRC = 5'h01;

endpackage

// file: core/io_line_cell.sv
// One line's conditioning stage: input synchroniser, inverter, driver and level capture.
module io_line_cell (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    // Line side
    input  wire logic pin_in,
    output logic      pin_out_q,
    output logic      pin_oe_q,
    // Control side
    input  wire logic src_bit,
    input  wire logic drive_en,
    input  wire logic invert,
    output logic      level_q
);

    logic sync1_q;
    logic sync2_q;
    logic out_d;
    logic level_d;

    assign out_d   = src_bit ^ invert;
    // A driven line (drive_en high) reports what it drives; otherwise the pin as seen through the inverter.
    assign level_d = drive_en ? out_d : (sync2_q ^ invert);

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            sync1_q   <= 1'b0;
            sync2_q   <= 1'b0;
            pin_out_q <= 1'b0;
            pin_oe_q  <= 1'b0;
            level_q   <= 1'b0;
        end else begin
            sync1_q   <= pin_in;
            sync2_q   <= sync1_q;
            pin_out_q <= out_d;
            pin_oe_q  <= drive_en;
            level_q   <= level_d;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    invert_out_a: assert property (pin_oe_q |-> pin_out_q == $past(src_bit ^ invert))
        else $error("driven level does not follow source through inverter");

    oe_gate_a: assert property (pin_oe_q != $past(drive_en) |-> $past(sys_rst))
        else $error("driver enable does not follow direction and source");

    sync_path_a: assert property (
        !$past(drive_en) && !$past(sys_rst) && !$past(sys_rst, 2) && !$past(sys_rst, 3)
        |-> level_q == ($past(pin_in, 3) ^ $past(invert)))
        else $error("input level not seen three cycles later through inverter");

endmodule

// file: core/line_io_control_block.sv
// Top of the line I/O control block: register port, per-line settings and user output bits.
//
// Decided for this implementation: strobed register access and the register addresses.
module line_io_control_block (
    // Clock and reset
    input  wire logic                              ref_clk,
    input  wire logic                              sys_rst,
    // Register port
    input  wire logic [line_io_pkg::ADDR_W-1:0]    reg_addr,
    input  wire logic [line_io_pkg::DATA_W-1:0]    reg_wdata,
    input  wire logic                              reg_wr,
    input  wire logic                              reg_rd,
    output logic      [line_io_pkg::DATA_W-1:0]    reg_rdata_q,
    // Lines: physical first, then virtual trigger lines
    input  wire logic [line_io_pkg::NUM_LINES-1:0] line_in,
    output logic      [line_io_pkg::NUM_LINES-1:0] line_out_q,
    output logic      [line_io_pkg::NUM_LINES-1:0] line_oe_q,
    // Internal sources and consumers
    input  wire logic [line_io_pkg::INT_SRCS-1:0]  int_src,
    output logic      [line_io_pkg::NUM_LINES-1:0] line_level_q,
    output logic      [line_io_pkg::USER_BITS-1:0] user_bits_q
);

    localparam int N = line_io_pkg::NUM_LINES;

    // Stored settings (line select, per-line, user select and mask) and the read mux output.
    logic [line_io_pkg::IDX_W-1:0]     sel_q;
    logic [N-1:0]                      dir_q;
    logic [N-1:0]                      inv_q;
    logic [line_io_pkg::SRC_W-1:0]     src_q [N];
    logic [line_io_pkg::IDX_W-1:0]     ubsel_q;
    logic [line_io_pkg::USER_BITS-1:0] mask_q;
    logic [line_io_pkg::DATA_W-1:0]    rd_d;

    // Effective settings after the line kind is applied.
    logic [N-1:0]                      dir_eff;
    logic [N-1:0]                      inv_eff;
    logic [line_io_pkg::SRC_W-1:0]     src_eff [N];
    logic [N-1:0]                      drive;
    logic [N-1:0]                      src_bit;
    logic [N-1:0]                      dir_ok;
    logic [N-1:0]                      inv_ok;
    logic [N-1:0]                      src_ok;
    logic [N-1:0]                      is_in_only;
    logic [N-1:0]                      is_out_only;
    logic [1:0]                        kind_code [N];
    logic [line_io_pkg::SRC_VEC_W-1:0] src_vec;

    // Write decode.
    wire wr_sel   = reg_wr && (reg_addr == line_io_pkg::OFS_LINE_SEL);
    wire wr_dir   = reg_wr && (reg_addr == line_io_pkg::OFS_LINE_DIR);
    wire wr_inv   = reg_wr && (reg_addr == line_io_pkg::OFS_LINE_INV);
    wire wr_src   = reg_wr && (reg_addr == line_io_pkg::OFS_LINE_SRC);
    wire wr_usel  = reg_wr && (reg_addr == line_io_pkg::OFS_USER_SEL);
    wire wr_uval  = reg_wr && (reg_addr == line_io_pkg::OFS_USER_VAL);
    wire wr_uword = reg_wr && (reg_addr == line_io_pkg::OFS_USER_WORD);
    wire wr_umask = reg_wr && (reg_addr == line_io_pkg::OFS_USER_MASK);

    // A selector value beyond the last line is refused so that stored indices stay in range.
    // The whole data word is compared, so a wide value cannot alias onto a low line or code.
    wire sel_valid = reg_wdata < line_io_pkg::DATA_W'(N);
    wire src_valid = reg_wdata < line_io_pkg::DATA_W'(line_io_pkg::SRC_COUNT);
    wire dir_take  = wr_dir && dir_ok[sel_q];
    wire inv_take  = wr_inv && inv_ok[sel_q];
    wire src_take  = wr_src && src_ok[sel_q] && src_valid;

    // Source vector: code 0 is off, then user bits, then internal sources.
    assign src_vec = {{(line_io_pkg::SRC_VEC_W - 1 - line_io_pkg::USER_BITS
                        - line_io_pkg::INT_SRCS){1'b0}},
                      int_src, user_bits_q, 1'b0};

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_line
            localparam line_io_pkg::line_kind_t K = line_io_pkg::LINE_KIND[g];
            assign is_in_only[g]  = (K == line_io_pkg::KIND_IN_ONLY);
            assign is_out_only[g] = (K == line_io_pkg::KIND_OUT_ONLY);
            assign dir_ok[g]      = (K == line_io_pkg::KIND_BIDIR);
            assign inv_ok[g]      = (K != line_io_pkg::KIND_FIXED);
            assign src_ok[g]      = (K == line_io_pkg::KIND_BIDIR) || is_out_only[g];
            assign kind_code[g]   = K;
            assign dir_eff[g]     = dir_ok[g] ? dir_q[g] :
                                    is_in_only[g] ? 1'b0 :
                                    is_out_only[g] ? 1'b1 :
                                    line_io_pkg::FIXED_DIR;
            assign inv_eff[g]     = inv_ok[g] ? inv_q[g] : line_io_pkg::FIXED_INV;
            assign src_eff[g]     = src_ok[g] ? src_q[g] :
                                    (K == line_io_pkg::KIND_FIXED) ? line_io_pkg::FIXED_SRC :
                                    line_io_pkg::SRC_OFF;
            assign drive[g]       = dir_eff[g] && (src_eff[g] != line_io_pkg::SRC_OFF);
            assign src_bit[g]     = src_vec[src_eff[g]];

            io_line_cell u_cell (
                .ref_clk   (ref_clk),
                .sys_rst   (sys_rst),
                .pin_in    (line_in[g]),
                .pin_out_q (line_out_q[g]),
                .pin_oe_q  (line_oe_q[g]),
                .src_bit   (src_bit[g]),
                .drive_en  (drive[g]),
                .invert    (inv_eff[g]),
                .level_q   (line_level_q[g])
            );
        end
    endgenerate

    // Line selector and per-line settings.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            sel_q <= line_io_pkg::RST_LINE_SEL;
            dir_q <= {N{line_io_pkg::RST_DIR}};
            inv_q <= {N{line_io_pkg::RST_INV}};
            for (int i = 0; i < N; i++) begin
                src_q[i] <= line_io_pkg::SRC_OFF;
            end
        end else begin
            if (wr_sel && sel_valid) begin
                sel_q <= reg_wdata[line_io_pkg::IDX_W-1:0];
            end
            if (dir_take) begin
                dir_q[sel_q] <= reg_wdata[0];
            end
            if (inv_take) begin
                inv_q[sel_q] <= reg_wdata[0];
            end
            if (src_take) begin
                src_q[sel_q] <= reg_wdata[line_io_pkg::SRC_W-1:0];
            end
        end
    end

    // User output bits: single-bit writes and masked word writes.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ubsel_q     <= line_io_pkg::RST_USER_SEL;
            mask_q      <= line_io_pkg::RST_MASK;
            user_bits_q <= line_io_pkg::RST_USER;
        end else begin
            if (wr_usel) begin
                ubsel_q <= reg_wdata[line_io_pkg::IDX_W-1:0];
            end
            if (wr_umask) begin
                mask_q <= reg_wdata[line_io_pkg::USER_BITS-1:0];
            end
            if (wr_uval) begin
                user_bits_q[ubsel_q] <= reg_wdata[0];
            end else if (wr_uword) begin
                user_bits_q <= (user_bits_q & ~mask_q)
                             | (reg_wdata[line_io_pkg::USER_BITS-1:0] & mask_q);
            end
        end
    end

    // Read selection; unmapped offsets and idle cycles return zero.
    always_comb begin
        rd_d = '0;
        if (!reg_rd) begin
            rd_d = '0;
        end else if (reg_addr == line_io_pkg::OFS_LINE_SEL) begin
            rd_d[line_io_pkg::IDX_W-1:0] = sel_q;
        end else if (reg_addr == line_io_pkg::OFS_LINE_DIR) begin
            rd_d[0] = dir_eff[sel_q];
        end else if (reg_addr == line_io_pkg::OFS_LINE_INV) begin
            rd_d[0] = inv_eff[sel_q];
        end else if (reg_addr == line_io_pkg::OFS_LINE_SRC) begin
            rd_d[line_io_pkg::SRC_W-1:0] = src_eff[sel_q];
        end else if (reg_addr == line_io_pkg::OFS_LINE_LEVEL) begin
            rd_d[0] = line_level_q[sel_q];
        end else if (reg_addr == line_io_pkg::OFS_ALL_LEVEL) begin
            rd_d[N-1:0] = line_level_q;
        end else if (reg_addr == line_io_pkg::OFS_USER_SEL) begin
            rd_d[line_io_pkg::IDX_W-1:0] = ubsel_q;
        end else if (reg_addr == line_io_pkg::OFS_USER_VAL) begin
            rd_d[0] = user_bits_q[ubsel_q];
        end else if (reg_addr == line_io_pkg::OFS_USER_WORD) begin
            rd_d[line_io_pkg::USER_BITS-1:0] = user_bits_q;
        end else if (reg_addr == line_io_pkg::OFS_USER_MASK) begin
            rd_d[line_io_pkg::USER_BITS-1:0] = mask_q;
        end else if (reg_addr == line_io_pkg::OFS_LINE_KIND) begin
            rd_d[1:0] = kind_code[sel_q];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            reg_rdata_q <= '0;
        end else begin
            reg_rdata_q <= rd_d;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    sequence dir_wr_s;
        reg_wr && (reg_addr == line_io_pkg::OFS_LINE_DIR) && dir_ok[sel_q];
    endsequence

    sequence uval_wr_s;
        reg_wr && (reg_addr == line_io_pkg::OFS_USER_VAL);
    endsequence

    sequence uword_wr_s;
        reg_wr && (reg_addr == line_io_pkg::OFS_USER_WORD);
    endsequence

    sequence lvl_rd_s;
        reg_rd && (reg_addr == line_io_pkg::OFS_LINE_LEVEL);
    endsequence

    reset_input_a: assert property ($fell(sys_rst) |-> dir_q == '0 && line_oe_q == '0)
        else $error("lines not input and undriven after reset");

    dir_write_a: assert property (dir_wr_s |=> dir_eff[$past(sel_q)] == $past(reg_wdata[0])
                                  ##1 line_oe_q == $past(drive))
        else $error("direction write not applied to selected line");

    fixed_ro_a: assert property (reg_wr |=> ((inv_q ^ $past(inv_q)) & ~inv_ok) == '0)
        else $error("hard-wired line setting changed by a write");

    in_only_a: assert property (((dir_eff | line_oe_q) & is_in_only) == '0)
        else $error("input-only line shows output direction or drive");

    out_only_a: assert property ((dir_eff & is_out_only) == is_out_only)
        else $error("output-only line does not report output direction");

    user_single_a: assert property (uval_wr_s |=>
                                    user_bits_q[$past(ubsel_q)] == $past(reg_wdata[0]))
        else $error("single user bit write not applied at selected index");

    user_mask_a: assert property (uword_wr_s |=>
        ((user_bits_q ^ $past(user_bits_q)) & ~$past(mask_q)) == '0 &&
        (user_bits_q & $past(mask_q)) ==
        ($past(reg_wdata[line_io_pkg::USER_BITS-1:0]) & $past(mask_q)))
        else $error("masked user word write wrong");

    all_word_a: assert property (reg_rd && reg_addr == line_io_pkg::OFS_ALL_LEVEL |=>
                                 reg_rdata_q == {{(32 - N){1'b0}}, $past(line_level_q)})
        else $error("all-lines level word wrong or misordered");

    readback_a: assert property (lvl_rd_s |=>
                                 reg_rdata_q == {31'h0000_0000, $past(line_level_q[sel_q])})
        else $error("selected line level readback wrong");

    // Refused values belong to these checks: an out-of-range select or source
    // write must leave the stored setting exactly as it was.
    sequence sel_wr_s;
        reg_wr && (reg_addr == line_io_pkg::OFS_LINE_SEL);
    endsequence

    sequence inv_wr_s;
        reg_wr && (reg_addr == line_io_pkg::OFS_LINE_INV) && inv_ok[sel_q];
    endsequence

    sequence src_wr_s;
        reg_wr && (reg_addr == line_io_pkg::OFS_LINE_SRC) && src_ok[sel_q];
    endsequence

    sel_refuse_a: assert property (sel_wr_s ##0 (reg_wdata >= 32'(N)) |=> $stable(sel_q))
        else $error("out-of-range line select was taken");

    inv_write_a: assert property (inv_wr_s |=> inv_eff[$past(sel_q)] == $past(reg_wdata[0]))
        else $error("inverter write not applied to selected line");

    src_write_a: assert property (src_wr_s ##0 (reg_wdata < 32'(line_io_pkg::SRC_COUNT)) |=>
                                  src_eff[$past(sel_q)] ==
                                  $past(reg_wdata[line_io_pkg::SRC_W-1:0]))
        else $error("source write not applied to selected line");

    src_refuse_a: assert property (src_wr_s ##0 (reg_wdata >= 32'(line_io_pkg::SRC_COUNT)) |=>
                                   src_eff[$past(sel_q)] == $past(src_eff[sel_q]))
        else $error("out-of-range source code was taken");

    src_off_a: assert property (src_wr_s ##0 (reg_wdata == 32'(line_io_pkg::SRC_OFF)) |->
                                ##2 !line_oe_q[$past(sel_q, 2)])
        else $error("line still driven after its source was switched off");

    // The reset edge itself is excluded, since the enable flops are cleared there.
    oe_follow_a: assert property (!$past(sys_rst) |-> line_oe_q == $past(drive))
        else $error("line driver enable does not follow direction and source");

    rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata_q == '0)
        else $error("read data present outside the cycle after a read");

    user_sel_a: assert property (uval_wr_s |=>
        ((user_bits_q ^ $past(user_bits_q)) & ~(8'h01 << $past(ubsel_q))) == '0)
        else $error("single user bit write disturbed another bit");

endmodule

// file: test/line_far_side.sv
// Connector and trigger-line model that resolves every line from all of its drivers.
module line_far_side (
    // Clock
    input  wire logic       ref_clk,
    // Device side
    input  wire logic [5:0] line_out_q,
    input  wire logic [5:0] line_oe_q,
    // Outside drivers set by the bench
    input  wire logic [5:0] ext_en,
    input  wire logic [5:0] ext_val,
    // Resolved line levels
    output logic      [5:0] line_in
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [5:0] float_q = 6'h00;

    // A line with no driver has no pull, so it wanders rather than keeping its last value.
    always_ff @(posedge ref_clk) begin
        float_q <= ~float_q;
    end

    always_comb begin
        for (int i = 0; i < 6; i++) begin
            if (line_oe_q[i]) begin
                line_in[i] = line_out_q[i];
            end else if (ext_en[i]) begin
                line_in[i] = ext_val[i];
            end else begin
                line_in[i] = float_q[i];
            end
        end
    end
endmodule

// file: test/line_io_control_block_tb.sv
// Self-checking bench of the line I/O control block with its connector model.
`define CHK(g, e) chk(32'(g), 32'(e))
module line_io_control_block_tb;
    timeunit 1ns;
    timeprecision 1ns;

    logic        ref_clk     = 1'b0;
    logic        sys_rst     = 1'b1;
    logic [7:0]  reg_addr    = 8'h00;
    logic [31:0] reg_wdata   = 32'h0000_0000;
    logic        reg_wr      = 1'b0;
    logic        reg_rd      = 1'b0;
    logic [5:0]  ext_en      = 6'h00;
    logic [5:0]  ext_val     = 6'h00;
    logic [7:0]  int_src     = 8'h00;
    logic [31:0] reg_rdata_q;
    logic [5:0]  line_in;
    logic [5:0]  line_out_q;
    logic [5:0]  line_oe_q;
    logic [5:0]  line_level_q;
    logic [7:0]  user_bits_q;
    int          miscompares = 0;
    int          checks      = 0;

    always #50 ref_clk = ~ref_clk;

    line_io_control_block u_line_io_control_block (.ref_clk, .sys_rst, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata_q, .line_in, .line_out_q, .line_oe_q, .int_src,
        .line_level_q, .user_bits_q);

    line_far_side u_line_far_side (.ref_clk, .line_out_q, .line_oe_q, .ext_en, .ext_val,
        .line_in);

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [31:0] m = 32'hFFFF_FFFF);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        `CHK(reg_rdata_q & m, e);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic t_reset();
        settle(1);
        `CHK(line_oe_q & 6'h37, 6'h00);
        rd(line_io_pkg::OFS_LINE_DIR, 32'h0000_0000);
        rd(line_io_pkg::OFS_LINE_INV, 32'h0000_0000);
        rd(line_io_pkg::OFS_LINE_SRC, 32'h0000_0000);
        rd(line_io_pkg::OFS_USER_MASK, 32'h0000_00FF);
        // An unmapped address reads as zero.
        rd(8'h3C, 32'h0000_0000);
        $display("Test reset finished");
    endtask

    task automatic t_input();
        @(posedge ref_clk);
        ext_en <= 6'h27;
        ext_val <= 6'h25;
        wr(line_io_pkg::OFS_LINE_SEL, 32'h0000_0001);
        wr(line_io_pkg::OFS_LINE_INV, 32'h0000_0001);
        settle(4);
        `CHK(line_level_q & 6'h2F, 6'h27);
        rd(line_io_pkg::OFS_LINE_LEVEL, 32'h0000_0001);
        rd(line_io_pkg::OFS_ALL_LEVEL, 32'h0000_0027, 32'h0000_002F);
        @(posedge ref_clk);
        ext_val <= 6'h24;
        settle(2);
        `CHK(line_level_q[0], 1'b1);
        settle(1);
        `CHK(line_level_q & 6'h2F, 6'h26);
        wr(line_io_pkg::OFS_LINE_SEL, 32'h0000_0005);
        rd(line_io_pkg::OFS_LINE_LEVEL, 32'h0000_0001);
        $display("Test input finished");
    endtask

    task automatic t_user();
        wr(line_io_pkg::OFS_USER_SEL, 32'h0000_0000);
        wr(line_io_pkg::OFS_USER_VAL, 32'h0000_0001);
        wr(line_io_pkg::OFS_USER_SEL, 32'h0000_0007);
        wr(line_io_pkg::OFS_USER_VAL, 32'h0000_0001);
        settle(1);
        `CHK(user_bits_q, 8'h81);
        rd(line_io_pkg::OFS_USER_VAL, 32'h0000_0001);
        wr(line_io_pkg::OFS_USER_MASK, 32'h0000_000F);
        wr(line_io_pkg::OFS_USER_WORD, 32'h0000_00F2);
        settle(1);
        `CHK(user_bits_q, 8'h82);
        wr(line_io_pkg::OFS_USER_MASK, 32'h0000_00F0);
        wr(line_io_pkg::OFS_USER_WORD, 32'h0000_00A0);
        rd(line_io_pkg::OFS_USER_WORD, 32'h0000_00A2);
        $display("Test user bits finished");
    endtask

    task automatic t_output();
        @(posedge ref_clk);
        ext_en <= 6'h26;
        wr(line_io_pkg::OFS_LINE_SEL, 32'h0000_0000);
        wr(line_io_pkg::OFS_LINE_DIR, 32'h0000_0001);
        wr(line_io_pkg::OFS_LINE_SRC, 32'(line_io_pkg::SRC_USER_BASE + 5'h01));
        settle(2);
        `CHK(line_oe_q[0], 1'b1);
        `CHK(line_out_q[0], 1'b1);
        rd(line_io_pkg::OFS_LINE_DIR, 32'h0000_0001);
        rd(line_io_pkg::OFS_LINE_LEVEL, 32'h0000_0001);
        wr(line_io_pkg::OFS_LINE_INV, 32'h0000_0001);
        wr(line_io_pkg::OFS_LINE_SRC, 32'(line_io_pkg::SRC_INT_BASE + 5'h03));
        settle(2);
        `CHK(line_out_q[0], 1'b1);
        @(posedge ref_clk);
        int_src <= 8'h08;
        settle(2);
        `CHK(line_out_q[0], 1'b0);
        rd(line_io_pkg::OFS_LINE_LEVEL, 32'h0000_0000);
        wr(line_io_pkg::OFS_LINE_SRC, 32'(line_io_pkg::SRC_OFF));
        settle(2);
        `CHK(line_oe_q[0], 1'b0);
        wr(line_io_pkg::OFS_LINE_SEL, 32'h0000_0001);
        wr(line_io_pkg::OFS_LINE_SRC, 32'(line_io_pkg::SRC_USER_BASE));
        settle(2);
        `CHK(line_oe_q[1], 1'b0);
        wr(line_io_pkg::OFS_LINE_SRC, 32'h0000_0011);
        wr(line_io_pkg::OFS_LINE_SRC, 32'h0000_0020);
        rd(line_io_pkg::OFS_LINE_SRC, 32'(line_io_pkg::SRC_USER_BASE));
        $display("Test output finished");
    endtask

    task automatic t_kinds();
        for (int i = 0; i < line_io_pkg::NUM_LINES; i++) begin
            wr(line_io_pkg::OFS_LINE_SEL, 32'(i));
            rd(line_io_pkg::OFS_LINE_KIND, 32'(line_io_pkg::LINE_KIND[i]));
        end
        wr(line_io_pkg::OFS_LINE_SEL, 32'h0000_0002);
        wr(line_io_pkg::OFS_LINE_DIR, 32'h0000_0001);
        rd(line_io_pkg::OFS_LINE_DIR, 32'h0000_0000);
        wr(line_io_pkg::OFS_LINE_SEL, 32'h0000_0003);
        wr(line_io_pkg::OFS_LINE_INV, 32'h0000_0001);
        rd(line_io_pkg::OFS_LINE_INV, 32'(line_io_pkg::FIXED_INV));
        rd(line_io_pkg::OFS_LINE_SRC, 32'(line_io_pkg::FIXED_SRC));
        wr(line_io_pkg::OFS_LINE_SEL, 32'h0000_0004);
        rd(line_io_pkg::OFS_LINE_DIR, 32'h0000_0001);
        wr(line_io_pkg::OFS_LINE_SEL, 32'h0000_0006);
        rd(line_io_pkg::OFS_LINE_SEL, 32'h0000_0004);
        wr(line_io_pkg::OFS_LINE_SEL, 32'h0000_0008);
        rd(line_io_pkg::OFS_LINE_SEL, 32'h0000_0004);
        $display("Test line kinds finished");
    endtask

    task automatic t_rerun();
        // Drive line zero first so that the reset has something to take away.
        wr(line_io_pkg::OFS_LINE_SEL, 32'h0000_0000);
        wr(line_io_pkg::OFS_LINE_SRC, 32'(line_io_pkg::SRC_USER_BASE));
        settle(2);
        `CHK(line_oe_q[0], 1'b1);
        @(posedge ref_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rd(line_io_pkg::OFS_LINE_DIR, 32'h0000_0000);
        `CHK(line_oe_q[0], 1'b0);
        $display("Test second reset finished");
    endtask

    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Every wait above is fixed, so this limit only guards against a stuck run.
    initial begin
        repeat (20000) @(posedge ref_clk);
        miscompares++;
        $display("MISMATCH at %0t: run limit reached", $time);
        tally_and_finish();
    end

    initial begin
        repeat (12) @(posedge ref_clk);
        sys_rst <= 1'b0;
        t_reset();
        t_input();
        t_user();
        t_output();
        t_kinds();
        t_rerun();
        tally_and_finish();
    end
endmodule
